// >>> hdl/pmc_top.sv
// power mode controller: mode state machine and output gating
`timescale 1ns/1ps
`default_nettype none
module pmc_top #(
  // wake hold time in clock cycles; a parameter so short runs can shrink it
  parameter int unsigned WAKE_CYC = pmc_pkg::WAKE_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire pmc_pkg::pmc_sense_t sense_i,
  input wire logic pushbutton_n_i,
  input wire logic low_power_request_n_i,
  input wire logic charge_enable_n_i,
  input wire logic ship_request_set_i,
  input wire logic ship_request_clear_i,
  input wire logic aux_output_enable_i,
  input wire logic host_busy_i,
  input wire logic battery_insert_i,
  output pmc_pkg::pmc_gate_t gate_o,
  output logic ship_request_bit_o,
  output logic [2:0] mode_o
);
  // ************************************************************
  // state
  // ************************************************************
  pmc_pkg::pmc_state_t state_r, state_nxt;
  logic [31:0] cnt_r;
  logic held_r;
  logic ship_req_r;
  logic bat_ok_r;
  logic ocp_r;
  logic aux_hold_r;

  wire logic in_valid = sense_i.in_above_uv;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // input present and below overvoltage: the only input that may feed the rail, and the charger except in a charge entry cycle from boot, probe, wake or ship
  function automatic logic in_usable(
    input pmc_pkg::pmc_sense_t s
  );
    in_usable = s.in_above_uv && !s.in_above_ovp;
  endfunction

  // ship entry waits for the input to go and the button to come up
  function automatic logic ship_ready(
    input logic req,
    input pmc_pkg::pmc_sense_t s,
    input logic pb_n
  );
    ship_ready = req && !s.in_above_uv && pb_n;
  endfunction

  // hysteresis state as it will be after this edge, so a trip acts without a cycle of lag
  function automatic logic bat_ok_now(
    input logic bat_ok,
    input pmc_pkg::pmc_sense_t s
  );
    bat_ok_now = s.bat_above_uv && (bat_ok || s.bat_above_uv_hyst);
  endfunction

  // battery switch may close on battery power
  function automatic logic switch_allowed(
    input logic bat_ok,
    input logic oc_hit,
    input pmc_pkg::pmc_sense_t s
  );
    switch_allowed = bat_ok_now(bat_ok, s) && !oc_hit && !s.discharge_oc;
  endfunction

  // code seen outside; probe and wake report as boot since no rail is up for the host yet
  function automatic logic [2:0] mode_code(
    input pmc_pkg::pmc_state_t st
  );
    case (st)
      pmc_pkg::PMC_SHIP: begin
        mode_code = 3'h1;
      end
      pmc_pkg::PMC_LOWPWR: begin
        mode_code = 3'h2;
      end
      pmc_pkg::PMC_ACTIVE: begin
        mode_code = 3'h3;
      end
      pmc_pkg::PMC_CHARGE: begin
        mode_code = 3'h4;
      end
      default: begin
        mode_code = 3'h0;
      end
    endcase
  endfunction

  // ************************************************************
  // ship request bit
  // ************************************************************
  // host clear; set wins over a simultaneous clear
  // being in ship mode (state_r == PMC_SHIP) also clears the bit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ship_req_r <= 1'b0;
    end else if (ship_request_set_i) begin
      ship_req_r <= 1'b1;
    end else if (ship_request_clear_i && in_valid) begin
      ship_req_r <= 1'b0;
    end else if (state_r == pmc_pkg::PMC_SHIP) begin
      ship_req_r <= 1'b0;
    end
  end

  // ************************************************************
  // battery undervoltage with hysteresis
  // ************************************************************
  // trip below threshold, release above threshold plus hysteresis
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bat_ok_r <= 1'b0;
    end else if (!sense_i.bat_above_uv) begin
      bat_ok_r <= 1'b0;
    end else if (sense_i.bat_above_uv_hyst) begin
      bat_ok_r <= 1'b1;
    end
  end

  // ************************************************************
  // overcurrent latch
  // ************************************************************
  // overcurrent trips switch; cleared when leaving battery operation
  // limitation: a trip keeps the switch open until input returns or ship is entered
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ocp_r <= 1'b0;
    end else if (sense_i.discharge_oc) begin
      ocp_r <= 1'b1;
    end else if (in_valid || state_r == pmc_pkg::PMC_SHIP) begin
      ocp_r <= 1'b0;
    end
  end

  // ************************************************************
  // wake hold counter: counts button low time
  // ************************************************************
  // button low time within one state, saturating at the hold time
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_r <= pmc_pkg::CNT_RST;
    end else if (state_r != state_nxt || pushbutton_n_i) begin
      cnt_r <= pmc_pkg::CNT_RST;
    end else if (cnt_r < WAKE_CYC) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // ************************************************************
  // held flag
  // ************************************************************
  // lasts one press: a refused release must not leave it armed for later
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      held_r <= 1'b0;
    end else if (state_r != state_nxt || pushbutton_n_i) begin
      held_r <= 1'b0;
    end else if (cnt_r >= WAKE_CYC) begin
      held_r <= 1'b1;
    end
  end

  // ************************************************************
  // aux output enable held through low power
  // ************************************************************
  // frozen on entry; the host cannot reach the bit while the serial side is down
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      aux_hold_r <= 1'b0;
    end else if (state_r != pmc_pkg::PMC_LOWPWR) begin
      aux_hold_r <= aux_output_enable_i;
    end
  end

  // ************************************************************
  // mode selection
  // ************************************************************
  // single machine, evaluated every cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pmc_pkg::PMC_BOOT: begin
        // input insertion wakes straight to charge mode
        if (in_valid) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        end else if (battery_insert_i) begin
          state_nxt = pmc_pkg::PMC_PROBE;
        end
      end
      pmc_pkg::PMC_PROBE: begin
        // rail raised briefly to sample the button
        // a button already up means nobody wants the system on, so back to ship
        if (in_valid) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        end else if (cnt_r >= pmc_pkg::PROBE_CYC || pushbutton_n_i) begin
          state_nxt = pushbutton_n_i ? pmc_pkg::PMC_SHIP : pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        // power up only after wake hold time
        // a release before the hold time counts as no wake
        if (in_valid) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        end else if (held_r) begin
          state_nxt = pmc_pkg::PMC_ACTIVE;
        end else if (pushbutton_n_i) begin
          state_nxt = pmc_pkg::PMC_SHIP;
        end
      end
      pmc_pkg::PMC_SHIP: begin
        // exit on input, or on held-and-released button with battery high
        if (in_valid) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        end else if (held_r && pushbutton_n_i && sense_i.bat_above_uv_max) begin
          state_nxt = pmc_pkg::PMC_ACTIVE;
        end
      end
      pmc_pkg::PMC_LOWPWR: begin
        // leave low power
        // an overvoltage input leaves the battery feeding the rail, never low power
        if (in_usable(sense_i)) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        end else if (low_power_request_n_i || !pushbutton_n_i || sense_i.in_above_ovp) begin
          state_nxt = pmc_pkg::PMC_ACTIVE;
        end
      end
      pmc_pkg::PMC_ACTIVE: begin
        // ship entry ignores charge enable, waits on input and button
        // checked first so a pending request wins as soon as its waits are over
        if (ship_ready(ship_req_r, sense_i, pushbutton_n_i)) begin
          state_nxt = pmc_pkg::PMC_SHIP;
        end else if (in_usable(sense_i)) begin
          state_nxt = pmc_pkg::PMC_CHARGE;
        // low power only when all conditions hold
        end else if (!low_power_request_n_i && !in_valid && pushbutton_n_i && !host_busy_i) begin
          state_nxt = pmc_pkg::PMC_LOWPWR;
        end
      end
      pmc_pkg::PMC_CHARGE: begin
        // input removal releases a pending ship entry
        if (!in_usable(sense_i)) begin
          state_nxt = (ship_ready(ship_req_r, sense_i, pushbutton_n_i) && !sense_i.in_above_ovp) ?
                      pmc_pkg::PMC_SHIP : pmc_pkg::PMC_ACTIVE;
        end
      end
      default: begin
        state_nxt = pmc_pkg::PMC_BOOT;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_r <= pmc_pkg::PMC_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // output gating, registered
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      gate_o <= '0;
    end else begin
      gate_o <= '0;
      case (state_nxt)
        pmc_pkg::PMC_PROBE, pmc_pkg::PMC_WAKE: begin
          // always-on rail up while button sampled
          gate_o.always_on_rail <= 1'b1;
          gate_o.osc_full <= 1'b1;
        end
        pmc_pkg::PMC_LOWPWR: begin
          // rail from battery, aux keeps its enable, rest off
          gate_o.always_on_rail <= 1'b1;
          // entry cycle still follows the bit, later cycles read the frozen copy
          gate_o.aux_output <= (state_r == pmc_pkg::PMC_LOWPWR) ? aux_hold_r : aux_output_enable_i;
          gate_o.battery_discharge_switch <= switch_allowed(bat_ok_r, ocp_r, sense_i);
        end
        pmc_pkg::PMC_ACTIVE: begin
          gate_o.always_on_rail <= 1'b1;
          gate_o.aux_output <= aux_output_enable_i;
          gate_o.battery_discharge_switch <= switch_allowed(bat_ok_r, ocp_r, sense_i);
          gate_o.serial_enable <= 1'b1;
          gate_o.interrupt_enable <= 1'b1;
          gate_o.converter_enable <= 1'b1;
          gate_o.osc_full <= 1'b1;
        end
        pmc_pkg::PMC_CHARGE: begin
          // converter continuous, rail from input in window
          gate_o.always_on_rail <= 1'b1;
          gate_o.aux_output <= aux_output_enable_i;
          gate_o.system_rail_from_in <= sense_i.in_above_bat_slp && !sense_i.in_above_ovp;
          gate_o.battery_discharge_switch <= !sense_i.discharge_oc;
          gate_o.serial_enable <= 1'b1;
          gate_o.interrupt_enable <= 1'b1;
          gate_o.converter_enable <= 1'b1;
          gate_o.osc_full <= 1'b1;
          gate_o.charge_active <= !charge_enable_n_i && !sense_i.charge_done;
        end
        default: begin
          // ship and boot: everything off, the cleared defaults above stand
        end
      endcase
    end
  end

  // ************************************************************
  // mode code output
  // ************************************************************
  // taken from the next state so the code changes on the same edge as the gates
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_o <= 3'h0;
    end else begin
      mode_o <= mode_code(state_nxt);
    end
  end

  // ************************************************************
  // ship request bit output
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ship_request_bit_o <= 1'b0;
    end else begin
      ship_request_bit_o <= ship_req_r;
    end
  end
endmodule
`default_nettype wire

// >>> include/pmc_pkg.sv
// package: constants and types for the power mode controller
`default_nettype none
package pmc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WAKE_HOLD_US = 1000;
  localparam int unsigned WAKE_HOLD_CYC = WAKE_HOLD_US * CLK_MHZ;
  localparam int unsigned PROBE_CYC = 4;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  typedef enum {PMC_BOOT, PMC_PROBE, PMC_WAKE, PMC_SHIP, PMC_LOWPWR, PMC_ACTIVE, PMC_CHARGE} pmc_state_t;

  // analog comparator results, all active high
  typedef struct packed {
    logic in_above_uv;
    logic in_above_ovp;
    logic in_above_bat_slp;
    logic bat_above_uv;
    logic bat_above_uv_hyst;
    logic bat_above_uv_max;
    logic discharge_oc;
    logic charge_done;
  } pmc_sense_t;

  typedef struct packed {
    logic always_on_rail;
    logic system_rail_from_in;
    logic battery_discharge_switch;
    logic aux_output;
    logic serial_enable;
    logic interrupt_enable;
    logic converter_enable;
    logic charge_active;
    logic osc_full;
  } pmc_gate_t;
endpackage
`default_nettype wire

// >>> bench/pmc_host_model.sv
// host and push-button model facing the mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
  input wire logic press_i,
  input wire logic xfer_i,
  output logic pushbutton_n_o,
  output logic host_busy_o
);
  // button pulled up
  // the line is high whenever nobody presses, and low exactly as long as a press lasts
  assign pushbutton_n_o = !press_i;
  assign host_busy_o = xfer_i;
endmodule
`default_nettype wire

// >>> bench/pmc_checker_assertions.sv
// checker: mode and gating relations of the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_checker (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire pmc_pkg::pmc_sense_t sense_i,
  input wire logic pushbutton_n_i,
  input wire logic low_power_request_n_i,
  input wire logic ship_request_set_i,
  input wire logic ship_request_clear_i,
  input wire pmc_pkg::pmc_gate_t gate_o,
  input wire logic ship_request_bit_o,
  input wire logic [2:0] mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  chk_ship_all_off: assert property (mode_o == 3'h1 |-> gate_o == '0)
    else $error("gates on in ship");
  chk_host_side_gate: assert property (gate_o.serial_enable || gate_o.interrupt_enable || gate_o.converter_enable
    |-> mode_o inside {3'h3, 3'h4}) else $error("host side on in wrong mode");
  chk_charge_in_charge: assert property (gate_o.charge_active |-> mode_o == 3'h4)
    else $error("charging outside charge mode");
  chk_lowpwr_quiet: assert property (mode_o == 3'h2 |-> gate_o.always_on_rail && !gate_o.serial_enable
    && !gate_o.converter_enable && !gate_o.osc_full) else $error("low power gating");
  chk_defer_input: assert property (sense_i.in_above_uv |=> mode_o != 3'h1)
    else $error("ship with input valid");
  chk_defer_button: assert property (!pushbutton_n_i && mode_o != 3'h1 |=> mode_o != 3'h1)
    else $error("ship with button low");
  chk_lowpwr_exit: assert property (mode_o == 3'h2 && (low_power_request_n_i || sense_i.in_above_uv)
    |=> mode_o != 3'h2) else $error("low power kept");
  chk_switch_cut: assert property (!sense_i.in_above_uv && (sense_i.discharge_oc || !sense_i.bat_above_uv)
    |=> !gate_o.battery_discharge_switch) else $error("switch stays on");
  chk_clear_taken: assert property (ship_request_clear_i && !ship_request_set_i && sense_i.in_above_uv
    |-> ##2 !ship_request_bit_o) else $error("ship request not cleared");
  chk_aux_frozen: assert property (mode_o == 3'h2 && $past(mode_o) == 3'h2 |-> $stable(gate_o.aux_output))
    else $error("aux output moved in low power");
  cover property (mode_o == 3'h1 ##1 mode_o == 3'h3);
  cover property (mode_o == 3'h2 ##1 mode_o == 3'h3);
  cover property (gate_o.charge_active);
endmodule
bind pmc_top pmc_checker u_pmc_checker (.mclk_i, .rst_b_i, .sense_i, .pushbutton_n_i, .low_power_request_n_i,
  .ship_request_set_i, .ship_request_clear_i, .gate_o, .ship_request_bit_o, .mode_o);
`default_nettype wire

// >>> bench/testbench.sv
// testbench: mode sequences of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  pmc_pkg::pmc_sense_t sense = '0;
  logic press = 1'b0;
  logic xfer = 1'b0;
  logic lp_n = 1'b1;
  logic ce_n = 1'b0;
  logic s_set = 1'b0;
  logic s_clr = 1'b0;
  logic aux_en = 1'b1;
  logic bat_ins = 1'b0;
  logic pb_n;
  logic busy;
  pmc_pkg::pmc_gate_t gate;
  logic s_bit;
  logic [2:0] mode;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  pmc_host_model u_pmc_host_model (.press_i(press), .xfer_i(xfer), .pushbutton_n_o(pb_n), .host_busy_o(busy));
  pmc_top #(.WAKE_CYC(20)) u_pmc_top (.mclk_i, .rst_b_i, .sense_i(sense), .pushbutton_n_i(pb_n),
    .low_power_request_n_i(lp_n), .charge_enable_n_i(ce_n), .ship_request_set_i(s_set),
    .ship_request_clear_i(s_clr), .aux_output_enable_i(aux_en), .host_busy_i(busy),
    .battery_insert_i(bat_ins), .gate_o(gate), .ship_request_bit_o(s_bit), .mode_o(mode));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic run(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic expect_mode(input logic [2:0] m);
    for (int i = 0; i < 60 && mode !== m; i++) @(negedge mclk_i);
    `CHK(mode, m)
  endtask
  task automatic pulse_press(input int n);
    press = 1'b1;
    run(n);
    press = 1'b0;
  endtask
  initial begin
    run(6);
    rst_b_i = 1'b1;
    `CHK(mode, 3'h0)
    sense.bat_above_uv = 1'b1;
    sense.bat_above_uv_hyst = 1'b1;
    bat_ins = 1'b1;
    expect_mode(3'h1);
    `CHK(gate, 9'h000)
    pulse_press(30);
    run(10);
    `CHK(mode, 3'h1)
    sense.bat_above_uv_max = 1'b1;
    pulse_press(30);
    expect_mode(3'h3);
    `CHK(gate.battery_discharge_switch, 1'b1)
    `CHK(gate.serial_enable, 1'b1)
    `CHK(gate.charge_active, 1'b0)
    xfer = 1'b1;
    lp_n = 1'b0;
    run(5);
    `CHK(mode, 3'h3)
    xfer = 1'b0;
    expect_mode(3'h2);
    `CHK(gate.aux_output, 1'b1)
    aux_en = 1'b0;
    run(3);
    `CHK(gate.aux_output, 1'b1)
    aux_en = 1'b1;
    press = 1'b1;
    expect_mode(3'h3);
    press = 1'b0;
    expect_mode(3'h2);
    lp_n = 1'b1;
    expect_mode(3'h3);
    lp_n = 1'b0;
    expect_mode(3'h2);
    sense.in_above_uv = 1'b1;
    sense.in_above_ovp = 1'b1;
    expect_mode(3'h3);
    sense.in_above_ovp = 1'b0;
    sense.in_above_bat_slp = 1'b1;
    expect_mode(3'h4);
    `CHK(gate.converter_enable, 1'b1)
    `CHK(gate.charge_active, 1'b1)
    `CHK(gate.system_rail_from_in, 1'b1)
    ce_n = 1'b1;
    s_set = 1'b1;
    run(1);
    s_set = 1'b0;
    run(5);
    `CHK(s_bit, 1'b1)
    `CHK(mode, 3'h4)
    s_clr = 1'b1;
    run(1);
    s_clr = 1'b0;
    run(2);
    `CHK(s_bit, 1'b0)
    s_set = 1'b1;
    press = 1'b1;
    run(1);
    s_set = 1'b0;
    sense.in_above_uv = 1'b0;
    sense.in_above_bat_slp = 1'b0;
    run(10);
    `CHK(mode, 3'h3)
    press = 1'b0;
    expect_mode(3'h1);
    lp_n = 1'b1;
    sense.in_above_uv = 1'b1;
    expect_mode(3'h4);
    sense.in_above_uv = 1'b0;
    expect_mode(3'h3);
    sense.discharge_oc = 1'b1;
    run(3);
    `CHK(gate.battery_discharge_switch, 1'b0)
    sense.discharge_oc = 1'b0;
    sense.in_above_uv = 1'b1;
    expect_mode(3'h4);
    sense.in_above_uv = 1'b0;
    expect_mode(3'h3);
    sense.bat_above_uv = 1'b0;
    sense.bat_above_uv_hyst = 1'b0;
    run(3);
    `CHK(gate.battery_discharge_switch, 1'b0)
    sense.bat_above_uv = 1'b1;
    run(3);
    `CHK(gate.battery_discharge_switch, 1'b0)
    sense.bat_above_uv_hyst = 1'b1;
    run(3);
    `CHK(gate.battery_discharge_switch, 1'b1)
    give_verdict();
  end
endmodule
`default_nettype wire
